// File: pkg/arp_pkg.sv
// shared constants, types and decode helpers for the adc result readout port
`default_nettype none

package arp_pkg;

  // ==========================================================================
  // data and channel layout
  localparam int RES_W = 16;
  localparam int NUM_CH_DEF = 8;
  localparam int BYTE_W = 8;

  // ==========================================================================
  // timing
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int REF_CLK_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
  // conversion time in ns; value arbitrary, no figure available
  localparam int CONV_TIME_NS = 4000;
  // longest time, so rounded down, never below one cycle
  localparam int CONV_CYC_RAW = CONV_TIME_NS / REF_CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;

  // ==========================================================================
  // reset values and counts
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [RES_W-1:0] DB_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_PAD = 8'h00;
  // synchroniser order: conv_start, iface, bsel, hbf, dual, cs_n, rd_n
  localparam int NSYNC = 7;
  localparam logic [NSYNC-1:0] SYNC_RST = 7'h03;
  // synchroniser bit positions
  localparam int SY_CSTART = 6;
  localparam int SY_IFACE = 5;
  localparam int SY_BSEL = 4;
  localparam int SY_HBF = 3;
  localparam int SY_DUAL = 2;
  localparam int SY_CS = 1;
  localparam int SY_RD = 0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ARP_PAR,
    ARP_BYTE,
    ARP_SER
  } arp_mode_t;

  typedef enum logic {
    ARP_IDLE,
    ARP_CONV
  } arp_conv_st_t;

  typedef struct packed {
    arp_mode_t mode;
    logic hbf;
    logic dual;
  } arp_cfg_t;

  typedef struct packed {
    logic [RES_W-1:0] data;
    logic oe_n;
  } arp_bus_t;

  // strap pair to interface mode; the two unlisted pairs fall back to parallel
  function automatic arp_mode_t arp_decode(input logic iface, input logic bsel);
    arp_mode_t m;
    m = ARP_PAR;
    case ({iface, bsel})
      2'b11: m = ARP_BYTE;
      2'b10: m = ARP_SER;
      default: m = ARP_PAR;
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// File: sim/arp_host.sv
// host model: chip select, read strobe and serial clock
`timescale 1ns/1ps
`default_nettype none

module arp_host
  import arp_pkg::*;
(
  input wire logic ref_clk,
  output logic cs_n,
  output logic rd_n,
  output logic sclk,
  input wire logic [RES_W-1:0] db_out,
  input wire logic first_channel_flag,
  input wire logic serial_out_a,
  input wire logic serial_out_b
);
  // serial clock idles high, runs only inside sword, selected or not
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk = 1'b1;
  end
  task automatic sel(input logic v);
    @(posedge ref_clk);
    cs_n <= v;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // one strobe; tied drops select with it
  task automatic strobe(input logic tied, output logic [RES_W-1:0] d, output logic f);
    @(posedge ref_clk);
    rd_n <= 1'b0;
    if (tied) cs_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #10;
    d = db_out;
    f = first_channel_flag;
    @(posedge ref_clk);
    rd_n <= 1'b1;
    if (tied) cs_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  // one word, sampled on falling serial clock
  task automatic sword(output logic [RES_W-1:0] a, output logic [RES_W-1:0] b,
      output logic [RES_W-1:0] f);
    for (int i = RES_W - 1; i >= 0; i--) begin
      #24;
      a[i] = serial_out_a;
      b[i] = serial_out_b;
      sclk = 1'b0;
      #1;
      f[i] = first_channel_flag;
      #23;
      sclk = 1'b1;
    end
  endtask
endmodule // arp_host

`default_nettype wire

// File: sim/arp_readout_sva.sv
// port checker for the adc result readout port
`timescale 1ns/1ps
`default_nettype none

module arp_readout_sva
  import arp_pkg::*;
#(
  parameter int CONV_CYCLES = 40
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic convert_start,
  input wire logic interface_type_select,
  input wire logic byte_mode_select,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic busy,
  input wire logic [RES_W-1:0] db_out,
  input wire logic db_oe_n,
  input wire logic first_flag_oe_n,
  input wire logic serial_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // helpers
  int busy_cnt;
  logic [2:0] strap_age;
  logic steady;
  logic ser_m;
  logic byte_m;
  assign steady = (strap_age == 3'h7);
  assign ser_m = steady && interface_type_select && !byte_mode_select;
  assign byte_m = steady && interface_type_select && byte_mode_select;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_age <= 3'h0;
    end else if (!$stable(interface_type_select) || !$stable(byte_mode_select)) begin
      strap_age <= 3'h0;
    end else if (!steady) begin
      strap_age <= strap_age + 3'h1;
    end
  end
  // ==========================================================================
  // assertions
  busy_start_a:
    assert property ($rose(convert_start) && !busy |-> ##[1:4] busy)
    else $error("busy did not follow start");
  busy_len_a:
    assert property ($fell(busy) |-> busy_cnt == CONV_CYCLES)
    else $error("busy width wrong");
  bus_on_a:
    assert property ($fell(cs_n) && steady && !ser_m |-> ##[2:4] !db_oe_n)
    else $error("bus not driven after select");
  bus_off_a:
    assert property ($rose(cs_n) |-> ##[2:4] db_oe_n)
    else $error("bus not released");
  flag_off_a:
    assert property ($rose(cs_n) |-> ##[2:4] first_flag_oe_n)
    else $error("flag not released");
  serial_off_a:
    assert property (cs_n |-> serial_oe_n)
    else $error("serial lines driven while deselected");
  serial_on_a:
    assert property (!cs_n && ser_m |-> !serial_oe_n && !first_flag_oe_n)
    else $error("serial lines idle while selected");
  byte_high_a:
    assert property (byte_m && !rd_n && $past(rd_n, 4) == 1'b0 |-> db_out[15:8] == 8'h00)
    else $error("byte mode upper lines not zero");
  cover property ($fell(busy));
  cover property (!serial_oe_n);
  cover property (byte_m && !db_oe_n);
endmodule // arp_readout_sva

`default_nettype wire

// File: sim/testbench.sv
// testbench for the adc result readout port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import arp_pkg::*;
  localparam int NCH = 8;
  logic ref_clk = 1'b0;
  logic arst_n, convert_start, iface, bsel, hbf, dual, cs_n, rd_n, sclk;
  logic busy, db_oe_n, flag, flag_oe_n, sa, sb, serial_oe_n;
  logic [RES_W-1:0] db_out;
  logic [NCH-1:0][RES_W-1:0] adc_data;
  logic [RES_W-1:0] res [NCH];
  logic [RES_W-1:0] db_pin;
  logic flag_pin, sa_pin, sb_pin;
  logic [31:0] rnd;
  // corner strap codes {dual, hbf, iface, bsel}, lowest nibble first
  localparam logic [19:0] CORNER = 20'h9E237;
  // released lines show the inverse, so a read off a floating line fails
  assign db_pin = db_oe_n ? ~db_out : db_out;
  assign flag_pin = flag_oe_n ? ~flag : flag;
  assign sa_pin = serial_oe_n ? ~sa : sa;
  assign sb_pin = serial_oe_n ? ~sb : sb;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  arp_readout #(.NUM_CH(NCH), .CONV_CYCLES(40)) i_arp_readout (.ref_clk(ref_clk),
    .arst_n(arst_n), .sclk(sclk), .convert_start(convert_start),
    .interface_type_select(iface), .byte_mode_select(bsel), .high_byte_first(hbf),
    .serial_dual_line(dual), .cs_n(cs_n), .rd_n(rd_n), .adc_data(adc_data), .busy(busy),
    .db_out(db_out), .db_oe_n(db_oe_n), .first_channel_flag(flag),
    .first_flag_oe_n(flag_oe_n), .serial_out_a(sa), .serial_out_b(sb),
    .serial_oe_n(serial_oe_n));
  arp_host i_arp_host (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk),
    .db_out(db_pin), .first_channel_flag(flag_pin), .serial_out_a(sa_pin),
    .serial_out_b(sb_pin));
  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic straps(input logic i, input logic b, input logic h, input logic d);
    @(posedge ref_clk);
    iface <= i;
    bsel <= b;
    hbf <= h;
    dual <= d;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic convert(input logic mid);
    logic [RES_W-1:0] d;
    logic f;
    int n;
    @(posedge ref_clk);
    for (int c = 0; c < NCH - 1; c++) adc_data[c] <= RES_W'($urandom);
    adc_data[NCH-1] <= 16'h80FF;
    convert_start <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    chk("busy_rise", busy, 1'b1);
    @(posedge ref_clk);
    convert_start <= 1'b0;
    if (mid) begin
      i_arp_host.sel(1'b0);
      i_arp_host.strobe(1'b0, d, f);
      i_arp_host.sel(1'b1);
      chk("old_sample", d, res[0]);
    end
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    chk("busy_fall", busy, 1'b0);
    for (int c = 0; c < NCH; c++) res[c] = adc_data[c];
  endtask
  task automatic par(input logic tied);
    logic [RES_W-1:0] d;
    logic f;
    if (!tied) i_arp_host.sel(1'b0);
    for (int i = 0; i < NCH; i++) begin
      i_arp_host.strobe(tied, d, f);
      chk("par_data", d, res[i]);
      chk("par_flag", f, i == 0);
    end
    i_arp_host.sel(1'b1);
    chk("bus_off", db_oe_n, 1'b1);
  endtask
  task automatic byt(input logic h);
    logic [RES_W-1:0] d, e;
    logic f;
    i_arp_host.sel(1'b0);
    for (int i = 0; i < 2 * NCH; i++) begin
      i_arp_host.strobe(1'b0, d, f);
      e = res[i/2];
      chk("byte", d, ((i % 2 == 0) == h) ? {8'h00, e[15:8]} : {8'h00, e[7:0]});
      chk("byte_flag", f, i < 2);
    end
    i_arp_host.sel(1'b1);
  endtask
  task automatic ser(input logic dl);
    logic [RES_W-1:0] a, b, f;
    int nw;
    nw = dl ? NCH / 2 : NCH;
    chk("ser_off", serial_oe_n, 1'b1);
    if (!dl) i_arp_host.sword(a, b, f);
    for (int w = 0; w < nw; w++) begin
      if (w == 0 || !dl) i_arp_host.sel(1'b0);
      i_arp_host.sword(a, b, f);
      chk("ser_a", a, res[w]);
      chk("ser_b", b, res[(w + NCH / 2) % NCH]);
      chk("ser_flag", f, (w == 0) ? 16'hFFFE : 16'h0000);
      if (w == nw - 1 || !dl) i_arp_host.sel(1'b1);
    end
  endtask
  // reset in the middle of a conversion
  task automatic rst_mid();
    @(posedge ref_clk);
    convert_start <= 1'b1;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b0;
    convert_start <= 1'b0;
    @(negedge ref_clk);
    chk("rst_busy", busy, 1'b0);
    chk("rst_bus", db_oe_n, 1'b1);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int c = 0; c < NCH; c++) res[c] = '0;
    repeat (4) @(posedge ref_clk);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    convert_start = 1'b0;
    iface = 1'b0;
    bsel = 1'b0;
    hbf = 1'b0;
    dual = 1'b0;
    adc_data = '0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    void'($urandom(43));
    repeat (4) @(posedge ref_clk);
    convert(1'b0);
    par(1'b0);
    par(1'b1);
    // first rounds walk the corner strap codes, the rest are random
    for (int k = 0; k < 12; k++) begin
      rnd = $urandom;
      if (k < 5) rnd[3:0] = CORNER[4*k +: 4];
      straps(rnd[1], rnd[0], rnd[2], rnd[3]);
      if (rnd[5]) convert(rnd[6] & ~rnd[1]);
      case (rnd[1:0])
        2'b11: byt(rnd[2]);
        2'b10: ser(rnd[3]);
        default: par(rnd[4]);
      endcase
    end
    straps(1'b0, 1'b0, 1'b0, 1'b0);
    convert(1'b1);
    par(1'b0);
    rst_mid();
    par(1'b0);
    convert(1'b0);
    par(1'b1);
    conclude();
  end
endmodule // testbench

bind arp_readout arp_readout_sva #(.CONV_CYCLES(CONV_CYCLES)) i_arp_readout_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .convert_start(convert_start),
  .interface_type_select(interface_type_select), .byte_mode_select(byte_mode_select),
  .cs_n(cs_n), .rd_n(rd_n), .busy(busy), .db_out(db_out), .db_oe_n(db_oe_n),
  .first_flag_oe_n(first_flag_oe_n), .serial_oe_n(serial_oe_n));

`default_nettype wire

// File: src/arp_readout.sv
// adc result readout port: result latch, parallel/byte reader, serial shifter
//
// What this block does and what its host is expected to do
// RULE1: results latch into the output registers when busy falls.
// RULE2: a read while busy is high returns the previous sample.
// RULE3: two strap pins choose parallel, byte or serial readout.
// RULE4: tied strobes: each fall drives the bus, channel 1 first with flag.
// RULE5: separate strobes: chip select enables bus, each read fall advances channel.
// RULE6: parallel flag drops at second read fall, tri-states at chip select rise.
// RULE7: byte mode sends each result as two bytes on the low lines.
// RULE8: high byte first input picks which byte goes out first.
// RULE9: host gives two read pulses per channel after chip select falls.
// RULE10: byte flag high for both channel 1 bytes, low from third fall.
// RULE11: chip select high tri-states serial lines and flag, ignores serial clock.
// RULE12: chip select fall drives msb; rising clock edges shift the rest.
// RULE13: sixteen clocks per channel, ascending; framing per word or whole.
// RULE14: line A sends group one then two; line B the reverse.
// RULE15: serial flag high from chip select fall to the 16th falling clock.
// RULE16: with both lines read, flag marks second group first channel too.
// RULE17: single line hosts should prefer line A for ascending order.
// RULE18: both lines together carry one group each, halving clock count.
// RULE19: shared bus hosts drive chip select and read separately.
// RULE20: host ends reads and raises chip select before busy falls.
// RULE21: every channel is converted and appears in the readout stream.
// RULE22: busy rises at conversion start and holds until conversion ends.
// RULE23: channel count is a parameter of 8, 6 or 4, halves form groups.
// RULE24: pointers return to channel 1 at busy fall and after full readout.
`timescale 1ns/1ps
`default_nettype none

module arp_readout
  import arp_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic convert_start,
  input wire logic interface_type_select,
  input wire logic byte_mode_select,
  input wire logic high_byte_first,
  input wire logic serial_dual_line,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [NUM_CH-1:0][RES_W-1:0] adc_data,
  output logic busy,
  output logic [RES_W-1:0] db_out,
  output logic db_oe_n,
  output logic first_channel_flag,
  output logic first_flag_oe_n,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic serial_oe_n
);

  // ==========================================================================
  // sizes
  localparam int HALF = NUM_CH / 2; // see RULE23
  localparam int CHW = $clog2(NUM_CH);
  localparam int PW = CHW + 1;
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [PW-1:0] PTR_RST = '0;
  localparam logic [PW-1:0] PAR_LAST = PW'(NUM_CH - 1);
  localparam logic [PW-1:0] BYTE_LAST = PW'(2 * NUM_CH - 1);
  localparam logic [CHW-1:0] CH_RST = '0;
  localparam logic [CHW-1:0] CH_LAST = CHW'(NUM_CH - 1);
  localparam logic [CHW-1:0] HALF_LAST = CHW'(HALF - 1);
  localparam logic [CHW-1:0] CH_HALF = CHW'(HALF);
  localparam logic [CW-1:0] CONV_LOAD = CW'(CONV_CYCLES - 1);
  localparam logic [CW-1:0] CNT_RST = '0;

  // wrapping increment for the parallel and byte read pointer
  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] v,
                                             input logic [PW-1:0] last);
    logic [PW-1:0] r;
    r = (v == last) ? PTR_RST : PW'(v + 1'b1);
    return r;
  endfunction

  // ==========================================================================
  // pin synchronisers
  // cs_n and rd_n reset high so no false strobe edge follows reset
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {convert_start, interface_type_select, byte_mode_select,
                  high_byte_first, serial_dual_line, cs_n, rd_n};
      sync_ff <= meta_ff;
    end
  end

  logic cstart_s;
  logic cs_n_s;
  logic strobe_n_s;
  assign cstart_s = sync_ff[SY_CSTART];
  assign cs_n_s = sync_ff[SY_CS];
  // tied or separate strobes both reduce to this combined strobe
  assign strobe_n_s = sync_ff[SY_CS] | sync_ff[SY_RD];

  // ==========================================================================
  // strap configuration
  arp_cfg_t cfg_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= '{mode: ARP_PAR, hbf: 1'b0, dual: 1'b0};
    end else begin
      cfg_ff.mode <= arp_decode(sync_ff[SY_IFACE], sync_ff[SY_BSEL]); // see RULE3
      cfg_ff.hbf <= sync_ff[SY_HBF];
      cfg_ff.dual <= sync_ff[SY_DUAL];
    end
  end

  // ==========================================================================
  // edge history
  logic cstart_prev_ff;
  logic strobe_prev_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cstart_prev_ff <= 1'b0;
      strobe_prev_ff <= 1'b1;
    end else begin
      cstart_prev_ff <= cstart_s;
      strobe_prev_ff <= strobe_n_s;
    end
  end

  logic cstart_rise;
  logic read_evt;
  assign cstart_rise = cstart_s & ~cstart_prev_ff;
  assign read_evt = (cfg_ff.mode != ARP_SER) & strobe_prev_ff & ~strobe_n_s;

  // ==========================================================================
  // conversion sequencer
  arp_conv_st_t state_ff;
  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  logic done;

  // done is the last busy cycle: results, the read pointer and, through ser_clear_ff, the serial pointer all move on it
  assign done = (state_ff == ARP_CONV) && (cnt_ff == CNT_RST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ARP_IDLE;
      cnt_ff <= CNT_RST;
      busy_ff <= 1'b0;
    end else begin
      case (state_ff)
        ARP_IDLE: begin
          // a start seen while busy is dropped: only idle looks at it
          if (cstart_rise) begin
            state_ff <= ARP_CONV;
            cnt_ff <= CONV_LOAD;
            busy_ff <= 1'b1; // see RULE22
          end
        end
        ARP_CONV: begin
          if (done) begin
            state_ff <= ARP_IDLE;
            busy_ff <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= ARP_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // output result registers, all channels every conversion
  logic [RES_W-1:0] res_ff [NUM_CH];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        res_ff[i] <= DB_RST;
      end
    end else if (done) begin
      // only here, so reads under busy see the old sample; see RULE1 RULE2 RULE21
      for (int i = 0; i < NUM_CH; i++) begin
        res_ff[i] <= adc_data[i];
      end
    end
  end

  // one-cycle clear of the serial channel pointer at busy fall
  // it acts as a reset of the link side, so no serial clock is needed
  logic ser_clear_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_clear_ff <= 1'b0;
    end else begin
      ser_clear_ff <= done; // see RULE24
    end
  end

  // ==========================================================================
  // parallel and byte readout
  logic [PW-1:0] ptr_ff;
  logic [PW-1:0] ptr_last;
  logic [CHW-1:0] byte_ch;
  logic hi_sel;
  logic [RES_W-1:0] byte_word;

  assign ptr_last = (cfg_ff.mode == ARP_BYTE) ? BYTE_LAST : PAR_LAST;
  assign byte_ch = ptr_ff[PW-1:1];
  assign hi_sel = cfg_ff.hbf ^ ptr_ff[0]; // see RULE8
  assign byte_word = res_ff[byte_ch];
  // a strobe in the busy-fall cycle loses to the pointer clear

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_ff <= PTR_RST;
    end else if (done) begin
      ptr_ff <= PTR_RST; // see RULE24
    end else if (read_evt) begin
      ptr_ff <= wrap_inc(ptr_ff, ptr_last); // see RULE5 RULE24
    end
  end

  arp_bus_t bus_ff;
  logic par_flag_ff;
  logic par_flag_oe_n_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_ff <= '{data: DB_RST, oe_n: 1'b1};
    end else begin
      bus_ff.oe_n <= (cfg_ff.mode == ARP_SER) | cs_n_s; // see RULE4 RULE5
      if (read_evt) begin
        if (cfg_ff.mode == ARP_BYTE) begin
          // low lines only, upper lines held at zero; see RULE7
          bus_ff.data <= {BYTE_PAD, hi_sel ? byte_word[RES_W-1:BYTE_W]
                                           : byte_word[BYTE_W-1:0]};
        end else begin
          bus_ff.data <= res_ff[ptr_ff[CHW-1:0]]; // see RULE4
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      par_flag_ff <= 1'b0;
      par_flag_oe_n_ff <= 1'b1;
    end else begin
      par_flag_oe_n_ff <= (cfg_ff.mode == ARP_SER) | cs_n_s; // see RULE6 RULE10
      // cleared while deselected so each frame starts low
      if (cs_n_s) begin
        par_flag_ff <= 1'b0;
      end else if (read_evt) begin
        if (cfg_ff.mode == ARP_BYTE) begin
          par_flag_ff <= (ptr_ff[PW-1:1] == CH_RST); // see RULE10
        end else begin
          par_flag_ff <= (ptr_ff == PTR_RST); // see RULE4 RULE6
        end
      end
    end
  end

  // ==========================================================================
  // serial link, runs on the host serial clock
  // result registers are static here: host keeps reads clear of busy fall
  logic ser_rst_n;
  logic bit_rst_n;
  assign ser_rst_n = arst_n & ~ser_clear_ff;
  assign bit_rst_n = arst_n & ~cs_n; // see RULE11

  logic [3:0] bit_ff;
  logic [CHW-1:0] ch_ff;
  logic low_ff;
  logic [CHW-1:0] ch_last;
  logic [CHW-1:0] b_idx;

  assign ch_last = cfg_ff.dual ? HALF_LAST : CH_LAST; // see RULE18
  // cs_n high holds the bit count at zero: a cut frame restarts at the msb

  always_ff @(posedge sclk or negedge bit_rst_n) begin
    if (!bit_rst_n) begin
      bit_ff <= BIT_RST;
    end else begin
      bit_ff <= bit_ff + 1'b1; // see RULE12 RULE13
    end
  end

  always_ff @(posedge sclk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      ch_ff <= CH_RST;
    end else if (bit_ff == BIT_LAST) begin
      ch_ff <= (ch_ff == ch_last) ? CH_RST : CHW'(ch_ff + 1'b1); // see RULE13 RULE24
    end
  end

  // marks the falling edge that samples a word's last bit
  always_ff @(negedge sclk or negedge bit_rst_n) begin
    if (!bit_rst_n) begin
      low_ff <= 1'b0;
    end else begin
      low_ff <= (bit_ff == BIT_LAST); // see RULE15
    end
  end

  // line B starts at the upper group and wraps into the lower one
  assign b_idx = (ch_ff >= CH_HALF) ? CHW'(ch_ff - CH_HALF)
                                    : CHW'(ch_ff + CH_HALF); // see RULE14

  logic ser_on;
  logic ser_flag;
  assign ser_on = (cfg_ff.mode == ARP_SER) & ~cs_n;
  // channel 0 on A is also the second group's first on B; see RULE16
  assign ser_flag = (ch_ff == CH_RST) & ~low_ff; // see RULE15

  // ==========================================================================
  // outputs
  // serial pins are combinational: they must answer cs_n without a clock
  assign busy = busy_ff;
  assign db_out = bus_ff.data;
  assign db_oe_n = bus_ff.oe_n;
  assign serial_out_a = res_ff[ch_ff][~bit_ff]; // see RULE12 RULE14
  assign serial_out_b = res_ff[b_idx][~bit_ff]; // see RULE14
  assign serial_oe_n = ~ser_on; // see RULE11
  assign first_channel_flag = (cfg_ff.mode == ARP_SER) ? ser_flag : par_flag_ff;
  assign first_flag_oe_n = (cfg_ff.mode == ARP_SER) ? ~ser_on : par_flag_oe_n_ff;

endmodule // arp_readout

`default_nettype wire
